/* shared/dma_req_pkg.sv */
package dma_req_pkg;

   // ****************************************************
   // geometry
   // ****************************************************
   localparam int NUM_CHANNELS = 3;
   localparam int OFFSET_W     = 12;

   // ****************************************************
   // register offsets (byte addresses)
   // ****************************************************
   localparam logic [11:0] SUMMARY_OFFSET    = 12'h360;
   localparam logic [11:0] SRC_SW_OFFSET     = 12'h368;
   localparam logic [11:0] DST_SW_OFFSET     = 12'h370;
   localparam logic [11:0] SRC_SINGLE_OFFSET = 12'h378;
   localparam logic [11:0] DST_SINGLE_OFFSET = 12'h380;
   localparam logic [11:0] EVT_STATUS_OFFSET = 12'h3C0;
   localparam logic [11:0] EVT_MASK_OFFSET   = 12'h3C4;

   // ****************************************************
   // field positions
   // ****************************************************
   localparam int REQ_LSB      = 0;
   localparam int WE_LSB       = 8;
   localparam int SUM_TFR_BIT  = 0;
   localparam int SUM_BLK_BIT  = 1;
   localparam int SUM_SRC_BIT  = 2;
   localparam int SUM_DST_BIT  = 3;
   localparam int SUM_ERR_BIT  = 4;
   localparam int EVT_SRC_SW   = 0;
   localparam int EVT_DST_SW   = 1;
   localparam int EVT_SRC_SGL  = 2;
   localparam int EVT_DST_SGL  = 3;
   localparam int NUM_EVENTS   = 4;

   // ****************************************************
   // reset values
   // ****************************************************
   localparam logic [2:0]  REQ_RESET   = 3'h0;
   localparam logic [3:0]  EVT_RESET   = 4'h0;
   localparam logic [3:0]  MASK_RESET  = 4'h0;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

   // ****************************************************
   // bus encodings
   // ****************************************************
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'h0;

   // ****************************************************
   // carriers
   // ****************************************************
   typedef struct packed {
      logic [2:0] err;
      logic [2:0] dst_txn;
      logic [2:0] src_txn;
      logic [2:0] block_done;
      logic [2:0] transfer_done;
   } masked_status_type;

   typedef struct packed {
      logic [2:0] src_sw;
      logic [2:0] dst_sw;
      logic [2:0] src_single;
      logic [2:0] dst_single;
   } request_set_type;

   typedef enum logic [3:0] {
      BUS_IDLE      = 4'h1,
      BUS_WRITE     = 4'h2,
      BUS_READ_WAIT = 4'h4,
      BUS_READ_DONE = 4'h8
   } bus_state_type;

endpackage

/* core/request_bank.sv */
`timescale 1ns/100ps
module request_bank import dma_req_pkg::*; #(
   parameter int CHANNELS = NUM_CHANNELS
) (
   input  wire logic                core_clk_i,
   input  wire logic                rst_n_i,
   input  wire logic                wr_i,
   input  wire logic [CHANNELS-1:0] wr_enable_i,
   input  wire logic [CHANNELS-1:0] wr_value_i,
   input  wire logic [CHANNELS-1:0] ack_i,
   output logic      [CHANNELS-1:0] request_o,
   output logic      [CHANNELS-1:0] served_o
);

   // ****************************************************
   // parameter check
   // ****************************************************
   if (CHANNELS < 1 || CHANNELS > 3) begin : g_bad_channels
      $error("request_bank: CHANNELS must be 1 to 3");
   end

   logic [CHANNELS-1:0] request_reg;
   logic [CHANNELS-1:0] request_next;
   wire  [CHANNELS-1:0] write_mask;

   // only lanes whose enable is set in this write move
   assign write_mask = wr_i ? wr_enable_i : '0;

   // software write wins over a same-cycle acknowledge so a
   // fresh request is never dropped
   assign request_next = (request_reg & ~ack_i & ~write_mask)
                       | (wr_value_i & write_mask);

   // a pending request that the engine retires this cycle
   assign served_o  = request_reg & ack_i & ~write_mask;
   assign request_o = request_reg;

   // request state
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         request_reg <= REQ_RESET[CHANNELS-1:0];
      end else begin
         request_reg <= request_next;
      end
   end

endmodule

/* core/dma_sw_handshake_requests.sv */
`timescale 1ns/100ps
// What this block does
// - summary bit 2 ORs masked source-transaction status
// - summary bit 1 ORs masked block-done status
// - summary bit 0 ORs masked transfer-done status
// - summary bit 3 ORs masked destination-transaction status
// - source request register at 0x368, bits 2:0
// - source request write enables at bits 10:8
// - destination request register at 0x370, bits 2:0
// - destination request write enables at bits 10:8
// - source single register at 0x378, bits 2:0
// - source single write enables at bits 10:8
// - destination single at 0x380, enables 10:8
// - request registers reset to all zeros
// - destination single bits show active request
module dma_sw_handshake_requests import dma_req_pkg::*; #(
   parameter int CHANNELS = NUM_CHANNELS
) (
   input  wire logic              core_clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              hsel_i,
   input  wire logic [31:0]       haddr_i,
   input  wire logic [1:0]        htrans_i,
   input  wire logic              hwrite_i,
   input  wire logic [2:0]        hsize_i,
   input  wire logic [31:0]       hwdata_i,
   input  wire logic              hready_i,
   output logic      [31:0]       hrdata_o,
   output logic                   hreadyout_o,
   output logic                   hresp_o,
   input  wire masked_status_type masked_status_i,
   input  wire request_set_type   request_ack_i,
   output request_set_type        request_o,
   output logic                   irq_o
);

   // ****************************************************
   // parameter check
   // ****************************************************
   if (CHANNELS != NUM_CHANNELS) begin : g_bad_channels
      $error("dma_sw_handshake_requests: CHANNELS must be 3");
   end

   // ****************************************************
   // helpers
   // ****************************************************

   // request field of a written word
   function automatic logic [2:0] req_field(
      input logic [31:0] data
   );
      req_field = data[REQ_LSB +: 3];
   endfunction

   // write-enable field of a written word
   function automatic logic [2:0] we_field(
      input logic [31:0] data
   );
      we_field = data[WE_LSB +: 3];
   endfunction

   // place request bits in a read word, the rest reads zero
   function automatic logic [31:0] pack_req(
      input logic [2:0] req
   );
      logic [31:0] word;
      word = 32'h0000_0000;
      word[REQ_LSB +: 3] = req;
      pack_req = word;
   endfunction

   // word-aligned offset match
   function automatic logic hit(
      input logic [OFFSET_W-1:0] addr,
      input logic [11:0]         offset
   );
      hit = (addr[OFFSET_W-1:2] == offset[OFFSET_W-1:2]);
   endfunction

   // ****************************************************
   // bus address phase
   // ****************************************************
   bus_state_type         state_reg;
   bus_state_type         state_next;
   logic [OFFSET_W-1:0]   addr_reg;
   logic [31:0]           rdata_reg;
   logic [31:0]           rdata_next;

   wire accept;
   wire [OFFSET_W-1:0] addr_next;

   // a transfer is taken only while the bus is ready; only
   // whole-word singles are expected, other sizes act alike
   assign accept = hsel_i & hready_i
                 & (htrans_i == HTRANS_NONSEQ);
   assign addr_next = accept ? haddr_i[OFFSET_W-1:0]
                             : addr_reg;

   // reads take one wait state so the data leaves a flop and
   // already sees a write made just before it
   always_comb begin
      state_next = BUS_IDLE;
      unique case (state_reg)
         BUS_IDLE, BUS_WRITE, BUS_READ_DONE: begin
            if (accept) begin
               state_next = hwrite_i ? BUS_WRITE
                                     : BUS_READ_WAIT;
            end
         end
         BUS_READ_WAIT: begin
            state_next = BUS_READ_DONE;
         end
         default: begin
            state_next = BUS_IDLE;
         end
      endcase
   end

   // bus state and captured address
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= BUS_IDLE;
         addr_reg  <= '0;
      end else begin
         state_reg <= state_next;
         addr_reg  <= addr_next;
      end
   end

   // ****************************************************
   // address decode
   // ****************************************************
   wire in_write;
   wire in_read_load;
   wire sel_summary;
   wire sel_src_sw;
   wire sel_dst_sw;
   wire sel_src_sgl;
   wire sel_dst_sgl;
   wire sel_evt_status;
   wire sel_evt_mask;

   assign in_write     = (state_reg == BUS_WRITE);
   assign in_read_load = (state_reg == BUS_READ_WAIT);

   // one select per mapped word
   assign sel_summary    = hit(addr_reg, SUMMARY_OFFSET);
   assign sel_src_sw     = hit(addr_reg, SRC_SW_OFFSET);
   assign sel_dst_sw     = hit(addr_reg, DST_SW_OFFSET);
   assign sel_src_sgl    = hit(addr_reg, SRC_SINGLE_OFFSET);
   assign sel_dst_sgl    = hit(addr_reg, DST_SINGLE_OFFSET);
   assign sel_evt_status = hit(addr_reg, EVT_STATUS_OFFSET);
   assign sel_evt_mask   = hit(addr_reg, EVT_MASK_OFFSET);

   // write strobes, valid while hwdata stands
   wire wr_src_sw;
   wire wr_dst_sw;
   wire wr_src_sgl;
   wire wr_dst_sgl;
   wire wr_evt_mask;

   assign wr_src_sw   = in_write & sel_src_sw;
   assign wr_dst_sw   = in_write & sel_dst_sw;
   assign wr_src_sgl  = in_write & sel_src_sgl;
   assign wr_dst_sgl  = in_write & sel_dst_sgl;
   assign wr_evt_mask = in_write & sel_evt_mask;

   // fields of the written word; bits 31:11 and 7:3 are
   // never looked at by the request registers
   wire [2:0] wr_value;
   wire [2:0] wr_enable;

   assign wr_value  = req_field(hwdata_i);
   assign wr_enable = we_field(hwdata_i);

   // ****************************************************
   // request registers
   // ****************************************************
   request_set_type req_now;
   request_set_type req_served;

   // source software transaction requests
   request_bank #(
      .CHANNELS (CHANNELS)
   ) u_src_sw (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .wr_i        (wr_src_sw),
      .wr_enable_i (wr_enable),
      .wr_value_i  (wr_value),
      .ack_i       (request_ack_i.src_sw),
      .request_o   (req_now.src_sw),
      .served_o    (req_served.src_sw)
   );

   // destination software transaction requests
   request_bank #(
      .CHANNELS (CHANNELS)
   ) u_dst_sw (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .wr_i        (wr_dst_sw),
      .wr_enable_i (wr_enable),
      .wr_value_i  (wr_value),
      .ack_i       (request_ack_i.dst_sw),
      .request_o   (req_now.dst_sw),
      .served_o    (req_served.dst_sw)
   );

   // source single transaction requests
   request_bank #(
      .CHANNELS (CHANNELS)
   ) u_src_sgl (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .wr_i        (wr_src_sgl),
      .wr_enable_i (wr_enable),
      .wr_value_i  (wr_value),
      .ack_i       (request_ack_i.src_single),
      .request_o   (req_now.src_single),
      .served_o    (req_served.src_single)
   );

   // destination single transaction requests
   request_bank #(
      .CHANNELS (CHANNELS)
   ) u_dst_sgl (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .wr_i        (wr_dst_sgl),
      .wr_enable_i (wr_enable),
      .wr_value_i  (wr_value),
      .ack_i       (request_ack_i.dst_single),
      .request_o   (req_now.dst_single),
      .served_o    (req_served.dst_single)
   );

   // request lines leave straight from the bank flops
   assign request_o = req_now;

   // ****************************************************
   // combined interrupt summary
   // ****************************************************
   wire [31:0] summary_word;

   // each of bits 4:0 is the OR across channels of one masked status; bits 31:5 read zero
   assign summary_word = {
      27'h000_0000,
      |masked_status_i.err,
      |masked_status_i.dst_txn,
      |masked_status_i.src_txn,
      |masked_status_i.block_done,
      |masked_status_i.transfer_done
   };

   // ****************************************************
   // served-request events and interrupt
   // ****************************************************
   logic [NUM_EVENTS-1:0] evt_status_reg;
   logic [NUM_EVENTS-1:0] evt_status_next;
   logic [NUM_EVENTS-1:0] evt_mask_reg;
   logic [NUM_EVENTS-1:0] evt_mask_next;
   logic                  irq_reg;

   wire [NUM_EVENTS-1:0] evt_set;
   wire                  evt_read_clear;

   // one event per register when the engine retires a request
   assign evt_set[EVT_SRC_SW]  = |req_served.src_sw;
   assign evt_set[EVT_DST_SW]  = |req_served.dst_sw;
   assign evt_set[EVT_SRC_SGL] = |req_served.src_single;
   assign evt_set[EVT_DST_SGL] = |req_served.dst_single;

   // the read that returns the status also clears it; a new
   // event in that very cycle survives for the next read
   assign evt_read_clear  = in_read_load & sel_evt_status;
   assign evt_status_next = (evt_read_clear ? '0 : evt_status_reg)
                          | evt_set;
   assign evt_mask_next   = wr_evt_mask
                          ? hwdata_i[NUM_EVENTS-1:0]
                          : evt_mask_reg;

   // sticky status, mask and registered interrupt level
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         evt_status_reg <= EVT_RESET;
         evt_mask_reg   <= MASK_RESET;
         irq_reg        <= 1'b0;
      end else begin
         evt_status_reg <= evt_status_next;
         evt_mask_reg   <= evt_mask_next;
         irq_reg        <= |(evt_status_next & evt_mask_next);
      end
   end

   assign irq_o = irq_reg;

   // ****************************************************
   // read data
   // ****************************************************

   // unmapped offsets read zero with an OKAY answer
   always_comb begin
      rdata_next = rdata_reg;
      if (in_read_load) begin
         rdata_next = 32'h0000_0000;
         if (sel_summary) begin
            rdata_next = summary_word;
         end else if (sel_src_sw) begin
            rdata_next = pack_req(req_now.src_sw);
         end else if (sel_dst_sw) begin
            rdata_next = pack_req(req_now.dst_sw);
         end else if (sel_src_sgl) begin
            rdata_next = pack_req(req_now.src_single);
         end else if (sel_dst_sgl) begin
            rdata_next = pack_req(req_now.dst_single);
         end else if (sel_evt_status) begin
            rdata_next[NUM_EVENTS-1:0] = evt_status_reg;
         end else if (sel_evt_mask) begin
            rdata_next[NUM_EVENTS-1:0] = evt_mask_reg;
         end
      end
   end

   // read data flop
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_reg <= RDATA_RESET;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // ****************************************************
   // bus answer
   // ****************************************************
   assign hrdata_o    = rdata_reg;
   assign hreadyout_o = (state_reg != BUS_READ_WAIT);
   assign hresp_o     = HRESP_OKAY;

endmodule

/* tb/dma_sw_handshake_requests_assertions.sv */
`timescale 1ns/100ps
module dma_sw_handshake_requests_assertions import dma_req_pkg::*; #(
   parameter int CHANNELS = NUM_CHANNELS
) (
   input wire logic              core_clk_i,
   input wire logic              rst_n_i,
   input wire logic              hsel_i,
   input wire logic [31:0]       haddr_i,
   input wire logic [1:0]        htrans_i,
   input wire logic              hwrite_i,
   input wire logic [31:0]       hwdata_i,
   input wire logic              hready_i,
   input wire logic [31:0]       hrdata_o,
   input wire masked_status_type masked_status_i,
   input wire request_set_type   request_ack_i,
   input wire request_set_type   request_o
);
   // ****************
   // helpers
   // ****************
   logic        take;
   logic        rd_take;
   logic        req_rd;
   logic        wr_phase;
   logic [11:0] wr_addr;

   // a transfer counts only with select, ready and NONSEQ together
   assign take = hsel_i & hready_i & (htrans_i == HTRANS_NONSEQ);
   assign rd_take = take & ~hwrite_i;
   assign req_rd = rd_take & (haddr_i[11:0] inside {SRC_SW_OFFSET,
      DST_SW_OFFSET, SRC_SINGLE_OFFSET, DST_SINGLE_OFFSET});

   // writes land at the edge ending the data phase, so track that phase
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_phase <= 1'b0;
         wr_addr  <= 12'h000;
      end else begin
         wr_phase <= take & hwrite_i;
         wr_addr  <= haddr_i[11:0];
      end
   end

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   // ****************
   // properties
   // ****************
   a_sum_src_or : assert property (
      rd_take && haddr_i[11:0] == SUMMARY_OFFSET |-> ##2
      hrdata_o[SUM_SRC_BIT] == |masked_status_i.src_txn)
      else $error("summary source bit wrong");
   a_sum_blk_or : assert property (
      rd_take && haddr_i[11:0] == SUMMARY_OFFSET |-> ##2
      hrdata_o[SUM_BLK_BIT] == |masked_status_i.block_done)
      else $error("summary block bit wrong");
   a_sum_tfr_or : assert property (
      rd_take && haddr_i[11:0] == SUMMARY_OFFSET |-> ##2
      hrdata_o[SUM_TFR_BIT] == |masked_status_i.transfer_done)
      else $error("summary transfer bit wrong");
   a_sum_dst_or : assert property (
      rd_take && haddr_i[11:0] == SUMMARY_OFFSET |-> ##2
      hrdata_o[SUM_DST_BIT] == |masked_status_i.dst_txn)
      else $error("summary destination bit wrong");
   a_reserved_read_zero : assert property (
      req_rd |-> ##2 hrdata_o[31:3] == 29'h0000_0000)
      else $error("reserved request bits not zero");
   a_ack_clears_req : assert property (
      (|(request_o & request_ack_i)) && !wr_phase |=>
      (request_o & $past(request_o & request_ack_i)) == 12'h000)
      else $error("served request not cleared");
   a_set_only_write : assert property (
      !wr_phase |=> (request_o & ~$past(request_o)) == 12'h000)
      else $error("request set without a write");
   a_src_we_gates : assert property (
      wr_phase && wr_addr == SRC_SW_OFFSET && hwdata_i[10:8] == 3'h0
      |=> request_o.src_sw ==
      ($past(request_o.src_sw) & ~$past(request_ack_i.src_sw)))
      else $error("source request changed without enable");
   a_dst_single_write : assert property (
      wr_phase && wr_addr == DST_SINGLE_OFFSET |=> request_o.dst_single ==
      (($past(hwdata_i[10:8]) & $past(hwdata_i[2:0]))
      | (~$past(hwdata_i[10:8]) & $past(request_o.dst_single)
      & ~$past(request_ack_i.dst_single))))
      else $error("destination single bits not as written");
endmodule

bind dma_sw_handshake_requests dma_sw_handshake_requests_assertions #(
   .CHANNELS(CHANNELS)
) chk (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
   .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
   .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
   .masked_status_i(masked_status_i), .request_ack_i(request_ack_i),
   .request_o(request_o)
);

/* tb/dma_sw_handshake_requests_bench.sv */
`timescale 1ns/100ps
`define CHK(nm, e, s) \
   begin \
      samples_checked++; \
      if ((s) !== (e)) begin \
         err_count++; \
         $display("MISMATCH %s exp %h seen %h", nm, e, s); \
      end \
   end
module dma_sw_handshake_requests_bench import dma_req_pkg::*;;
   logic              core_clk_i;
   logic              rst_n_i;
   logic              hsel_i;
   logic [31:0]       haddr_i;
   logic [1:0]        htrans_i;
   logic              hwrite_i;
   logic [2:0]        hsize_i;
   logic [31:0]       hwdata_i;
   logic              hready_i;
   logic [31:0]       hrdata_o;
   logic              hreadyout_o;
   logic              hresp_o;
   masked_status_type masked_status_i;
   masked_status_type sv;
   request_set_type   request_ack_i;
   request_set_type   request_o;
   logic              irq_o;
   logic              irq_e;
   int                err_count;
   int                samples_checked;
   logic              rd_ph;
   logic              rq_chk;
   logic [31:0]       rnd;
   logic [31:0]       exp_d;
   logic [12:0]       exp_r;
   logic [2:0]        m [4];
   logic [11:0]       offs [4];
   logic [31:0]       rd_q [$];
   logic [12:0]       rq_q [$];

   // the one slave's ready is the bus ready
   assign hready_i = hreadyout_o;

   dma_sw_handshake_requests dut (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
      .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
      .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .masked_status_i(masked_status_i), .request_ack_i(request_ack_i),
      .request_o(request_o), .irq_o(irq_o)
   );

   // free-running 25 MHz clock
   initial begin
      core_clk_i = 1'b0;
      forever #20 core_clk_i = ~core_clk_i;
   end

   // ****************
   // tasks
   // ****************
   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction

   task automatic close_out;
      if (err_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ready is sampled at the rising edge, before the flops move
   task automatic wait_rdy;
      do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
   endtask

   task automatic xfer(input logic w, input logic [11:0] a);
      hsel_i   <= 1'b1;
      haddr_i  <= {20'h00000, a};
      htrans_i <= HTRANS_NONSEQ;
      hwrite_i <= w;
      wait_rdy();
      htrans_i <= 2'h0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a);
      hwdata_i <= d;
      wait_rdy();
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a);
      rd_ph <= 1'b1;
      rd_q.push_back(e);
      wait_rdy();
      rd_ph <= 1'b0;
   endtask

   // note expected requests and interrupt for the next edge
   task automatic note_req;
      rq_q.push_back({irq_e, m[0], m[1], m[2], m[3]});
      rq_chk <= 1'b1;
      @(posedge core_clk_i);
      rq_chk <= 1'b0;
   endtask

   // write one request register, mirror it in the model, read back
   task automatic wq(input int i, input logic [31:0] d);
      m[i] = (m[i] & ~d[10:8]) | (d[10:8] & d[2:0]);
      wr(offs[i], d);
      note_req();
      rd(offs[i], {29'h0000_0000, m[i]});
   endtask

   // one-cycle service pulse; only pending bits clear
   task automatic ack(input logic [11:0] a);
      request_ack_i <= a;
      @(posedge core_clk_i);
      request_ack_i <= 12'h000;
      {m[0], m[1], m[2], m[3]} = {m[0], m[1], m[2], m[3]} & ~a;
      note_req();
   endtask

   // results are matched to the oldest note as they appear
   always @(posedge core_clk_i) begin
      if (rd_ph && hreadyout_o) begin
         exp_d = rd_q.pop_front();
         `CHK("hrdata_o", exp_d, hrdata_o)
         `CHK("hresp_o", HRESP_OKAY, hresp_o)
      end
      if (rq_chk) begin
         exp_r = rq_q.pop_front();
         `CHK("request_o", exp_r, {irq_o, request_o})
      end
   end

   // a hang ends the run well beyond the expected few hundred cycles
   initial begin
      repeat (20000) @(posedge core_clk_i);
      err_count++;
      close_out();
   end

   // ****************
   // sequence
   // ****************
   initial begin
      rnd = 32'h0001_2A95;
      offs = '{SRC_SW_OFFSET, DST_SW_OFFSET, SRC_SINGLE_OFFSET,
               DST_SINGLE_OFFSET};
      foreach (m[i]) m[i] = 3'h0;
      {err_count, samples_checked} = {32'h0, 32'h0};
      {rst_n_i, hsel_i, hwrite_i, rd_ph, rq_chk, irq_e} = 6'h00;
      {haddr_i, hwdata_i, htrans_i, hsize_i} = {64'h0, 2'h0, 3'h2};
      masked_status_i = 15'h0000;
      request_ack_i = 12'h000;
      repeat (6) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      @(posedge core_clk_i);
      note_req();
      foreach (offs[i]) rd(offs[i], 32'h0000_0000);
      rd(EVT_MASK_OFFSET, 32'h0000_0000);
      rd(12'hFFC, 32'h0000_0000);
      // all set, one enable, data without enables, then random words
      for (int i = 0; i < 4; i++) begin
         wq(i, 32'hFFFF_FFFF);
         wq(i, 32'h0000_0200);
         wq(i, 32'h0000_0007);
         repeat (4) begin
            rnd = xs(rnd);
            wq(i, rnd);
         end
         wq(i, 32'h0000_0707);
      end
      // unmasked service raises the interrupt; the read clears it
      wr(EVT_MASK_OFFSET, 32'h0000_000F);
      irq_e = 1'b1;
      ack(12'h800);
      rd(EVT_STATUS_OFFSET, 32'h0000_0001);
      irq_e = 1'b0;
      note_req();
      rd(EVT_STATUS_OFFSET, 32'h0000_0000);
      ack(12'h800);
      rd(EVT_STATUS_OFFSET, 32'h0000_0000);
      // masked service is still recorded but stays quiet
      wr(EVT_MASK_OFFSET, 32'h0000_0000);
      ack(12'h007);
      rd(EVT_STATUS_OFFSET, 32'h0000_0008);
      // summary ORs each status group; writing it has no effect
      wr(SUMMARY_OFFSET, 32'hFFFF_FFFF);
      for (int k = 0; k < 20; k++) begin
         rnd = xs(rnd);
         sv = (k < 15) ? (15'h0001 << k) : rnd[14:0];
         masked_status_i <= sv;
         rd(SUMMARY_OFFSET, {27'h0, |sv.err, |sv.dst_txn, |sv.src_txn,
            |sv.block_done, |sv.transfer_done});
      end
      // a reset in mid-run drops every request
      rst_n_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      foreach (m[i]) m[i] = 3'h0;
      @(posedge core_clk_i);
      note_req();
      rd(offs[2], 32'h0000_0000);
      close_out();
   end
endmodule
